// [rtl/ext_data_access.sv]
// External-move access timing: stretch, wait states and address forming
module ext_data_access (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Clock control and memory map register writes
    input wire logic clock_control_wr,
    input wire logic [7:0] clock_control_wdata,
    input wire logic memory_map_wr,
    input wire logic [7:0] memory_map_wdata,
    input wire logic timed_access_open,
    // Special register write port and pointer control
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic pointer_select_toggle,
    input wire logic pointer_load,
    input wire logic [15:0] pointer_load_value,
    input wire logic pointer_inc,
    // External move request from the core
    input wire logic xmove_req,
    input wire xmove_pkg::xmove_request_type xmove_cmd,
    output logic xmove_ready,
    output logic xmove_done,
    output logic [7:0] read_data,
    output logic core_hold,
    // External memory side
    input wire logic port4_bit0,
    input wire logic [7:0] mem_rdata,
    output xmove_pkg::xmem_bus_type mem_bus,
    // Register state out
    output logic [7:0] clock_control_reg,
    output logic [7:0] memory_map_reg,
    output logic [7:0] pointer_select_reg,
    output logic [15:0] data_pointer_primary,
    output logic [15:0] data_pointer_secondary,
    output logic [1:0] clock_state
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    xmove_pkg::xmove_state_type state;
    xmove_pkg::xmove_state_type next_state;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [2:0] stretch_select;
    logic [2:0] next_stretch_select;
    logic wait_enable;
    logic next_wait_enable;
    logic [2:0] stretch_used;
    logic [2:0] next_stretch_used;
    logic [2:0] remaining;
    logic [2:0] next_remaining;
    logic first_cycle;
    logic next_first_cycle;
    logic held;
    logic next_held;
    logic is_write;
    logic next_is_write;
    logic [15:0] address;
    logic [15:0] next_address;
    logic [7:0] write_data;
    logic [7:0] next_write_data;
    logic strobe;
    logic next_strobe;
    logic done;
    logic next_done;
    logic [7:0] read_latch;
    logic [7:0] next_read_latch;
    logic wait_active;
    logic pointer_select;
    logic [15:0] selected_pointer;
    logic sample_point;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Clock states in which the strobe is active for a given position
    function automatic logic strobe_window(input logic [2:0] stretch, input logic first,
                                           input logic [2:0] rem, input logic [1:0] ph,
                                           input logic hold);
        logic on;
        on = 1'b0;
        if (stretch == 3'h0) begin
            on = (rem == 3'h0) && (ph == xmove_pkg::STATE_C2 || ph == xmove_pkg::STATE_C3 || hold);
        end else if (first) begin
            on = (ph == xmove_pkg::STATE_C3 || ph == xmove_pkg::STATE_C4);
        end else begin
            on = (rem != 3'h0) || (ph == xmove_pkg::STATE_C1 || ph == xmove_pkg::STATE_C2);
        end
        return on;
    endfunction

    // ****************************************************************
    // Submodules
    // ****************************************************************
    wait_sync u_wait_sync (
        .clk(clk),
        .rstn(rstn),
        .port4_bit0(port4_bit0),
        .wait_active(wait_active)
    );

    pointer_bank u_pointer_bank (
        .clk(clk),
        .rstn(rstn),
        .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .pointer_select_toggle(pointer_select_toggle),
        .pointer_load(pointer_load),
        .pointer_load_value(pointer_load_value),
        .pointer_inc(pointer_inc),
        .pointer_select(pointer_select),
        .data_pointer_primary(data_pointer_primary),
        .data_pointer_secondary(data_pointer_secondary),
        .selected_pointer(selected_pointer)
    );

    // ****************************************************************
    // Configuration registers
    // ****************************************************************

    // Stretch is free to write; wait enable needs the timed-access window
    always_comb begin
        next_stretch_select = stretch_select;
        next_wait_enable = wait_enable;
        if (clock_control_wr) begin
            next_stretch_select = clock_control_wdata[xmove_pkg::STRETCH_LSB +: xmove_pkg::STRETCH_WIDTH];
        end
        if (memory_map_wr && timed_access_open) begin
            next_wait_enable = memory_map_wdata[xmove_pkg::WAIT_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stretch_select <= xmove_pkg::STRETCH_RESET;
            wait_enable <= xmove_pkg::WAIT_ENABLE_RESET;
        end else begin
            stretch_select <= next_stretch_select;
            wait_enable <= next_wait_enable;
        end
    end

    // ****************************************************************
    // Machine cycle sequencer
    // ****************************************************************

    // Wait is looked at in the third state of the deciding cycle only
    assign sample_point = wait_enable && state == xmove_pkg::XM_ACCESS && phase == xmove_pkg::STATE_C3
        && remaining == ((stretch_used == 3'h0) ? 3'h0 : 3'h1);

    // Next state of the access sequencer
    always_comb begin
        next_phase = 2'(phase + 2'h1);
        next_state = state;
        next_stretch_used = stretch_used;
        next_remaining = remaining;
        next_first_cycle = first_cycle;
        next_held = held;
        next_is_write = is_write;
        next_address = address;
        next_write_data = write_data;
        next_done = 1'b0;
        next_read_latch = read_latch;
        if (sample_point) begin
            next_held = wait_active;
        end
        case (state)
            xmove_pkg::XM_IDLE: begin
                if (xmove_req && phase == xmove_pkg::STATE_C4) begin
                    next_state = xmove_pkg::XM_FETCH;
                    next_is_write = xmove_cmd.write;
                    next_write_data = xmove_cmd.write_data;
                    if (xmove_cmd.use_pointer) begin
                        next_address = selected_pointer;
                    end else begin
                        next_address = {xmove_cmd.port2_latch, xmove_cmd.indirect_register};
                    end
                end
            end
            xmove_pkg::XM_FETCH: begin
                // Snapshot stretch so a mid-access write cannot upset timing
                if (phase == xmove_pkg::STATE_C4) begin
                    next_state = xmove_pkg::XM_ACCESS;
                    next_stretch_used = stretch_select;
                    next_remaining = stretch_select;
                    next_first_cycle = 1'b1;
                    next_held = 1'b0;
                end
            end
            xmove_pkg::XM_ACCESS: begin
                if (phase == xmove_pkg::STATE_C4) begin
                    next_first_cycle = 1'b0;
                    if (held) begin
                        next_remaining = remaining;
                    end else if (remaining == 3'h0) begin
                        next_state = xmove_pkg::XM_IDLE;
                        next_done = 1'b1;
                    end else begin
                        next_remaining = 3'(remaining - 3'h1);
                    end
                end
                // Read data captured on every clock of the strobe; the last one is kept
                if (strobe && !is_write) begin
                    next_read_latch = mem_rdata;
                end
            end
            default: begin
                next_state = xmove_pkg::XM_IDLE;
            end
        endcase
        next_strobe = (next_state == xmove_pkg::XM_ACCESS)
            && strobe_window(next_stretch_used, next_first_cycle, next_remaining, next_phase, next_held);
    end

    // Register the sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= xmove_pkg::XM_IDLE;
            phase <= xmove_pkg::STATE_C1;
            stretch_used <= xmove_pkg::STRETCH_RESET;
            remaining <= 3'h0;
            first_cycle <= 1'b0;
            held <= 1'b0;
            is_write <= 1'b0;
            address <= xmove_pkg::POINTER_RESET;
            write_data <= xmove_pkg::BYTE_ZERO;
            strobe <= 1'b0;
            done <= 1'b0;
            read_latch <= xmove_pkg::BYTE_ZERO;
        end else begin
            state <= next_state;
            phase <= next_phase;
            stretch_used <= next_stretch_used;
            remaining <= next_remaining;
            first_cycle <= next_first_cycle;
            held <= next_held;
            is_write <= next_is_write;
            address <= next_address;
            write_data <= next_write_data;
            strobe <= next_strobe;
            done <= next_done;
            read_latch <= next_read_latch;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Address is driven from the fetch cycle onward
    assign mem_bus.address = address;
    assign mem_bus.write_data = write_data;
    assign mem_bus.rd_n = ~(strobe && !is_write);
    assign mem_bus.wr_n = ~(strobe && is_write);

    // Core is held through every cycle past the normal two
    assign core_hold = (state == xmove_pkg::XM_ACCESS) && !(remaining == 3'h0 && !held);
    assign xmove_ready = (state == xmove_pkg::XM_IDLE) && (phase == xmove_pkg::STATE_C4);
    assign xmove_done = done;
    assign read_data = read_latch;
    assign clock_state = phase;

    // Register readback; unused bits read zero
    assign clock_control_reg = {5'h00, stretch_select};
    assign memory_map_reg = {wait_enable, 7'h00};
    assign pointer_select_reg = {7'h00, pointer_select};

endmodule

// [rtl/xmove_pkg.sv]
// Constants and shared types for the external-move access timing block
// ****************************************************************
// Operation
// - An external move starts with a 4-clock opcode fetch, then the address cycle.
// - Stretch comes from the low three bits of the clock control register.
// - Stretch 0 to 7 gives an external move of 2 to 9 machine cycles.
// - Stretch resets to one, three cycles; software may write zero.
// - Strobe lasts 2 clocks at stretch 0, else 4 clocks per stretch step.
// - Only the external move is lengthened; the core is held meanwhile.
// - The wait input is the alternate function of port4_bit0.
// - Wait input is honoured only while wait_enable, memory map bit 7, is set.
// - With wait enabled, stretch sets the minimum length; wait only lengthens.
// - Wait is sampled in the third clock state of the deciding cycle only, before the strobe ends.
// - A sampled active wait inserts one more machine cycle, strobe held active.
// - Wait cycles are unlimited; the access ends once wait is seen released.
// - wait_enable is written only inside the timed-access window.
// - pointer_select clear uses the primary pointer, set uses the secondary.
// - pointer_select lives at 86h, bit 0 only, others zero; pointer_select_toggle flips it.
// - Register-indirect address is port 2 latch high, indirect register low.
// - A machine cycle is four clock states in fixed order.
// ****************************************************************
package xmove_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
    localparam int FETCH_CLOCKS = 4;
    localparam logic [1:0] STATE_C1 = 2'h0;
    localparam logic [1:0] STATE_C2 = 2'h1;
    localparam logic [1:0] STATE_C3 = 2'h2;
    localparam logic [1:0] STATE_C4 = 2'h3;

    // ****************************************************************
    // Registers and fields
    // ****************************************************************
    localparam int STRETCH_LSB = 0;
    localparam int STRETCH_WIDTH = 3;
    localparam logic [2:0] STRETCH_RESET = 3'h1;
    localparam int WAIT_ENABLE_BIT = 7;
    localparam logic WAIT_ENABLE_RESET = 1'b0;
    localparam logic [7:0] POINTER_SELECT_ADDR = 8'h86;
    localparam int POINTER_SELECT_BIT = 0;
    localparam logic POINTER_SELECT_RESET = 1'b0;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum {
        XM_IDLE,
        XM_FETCH,
        XM_ACCESS
    } xmove_state_type;

    typedef struct packed {
        logic write;
        logic use_pointer;
        logic [7:0] indirect_register;
        logic [7:0] port2_latch;
        logic [7:0] write_data;
    } xmove_request_type;

    typedef struct packed {
        logic [15:0] address;
        logic [7:0] write_data;
        logic rd_n;
        logic wr_n;
    } xmem_bus_type;

endpackage

// [rtl/wait_sync.sv]
// Three-stage synchroniser and agreement filter for the active-low wait pin
module wait_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pin side
    input wire logic port4_bit0,
    // Core side
    output logic wait_active
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic level;
    logic next_level;

    // Level changes only when stages two and three agree
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = ~stage2;
        end
    end

    // Idle pin is high, so reset to released
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level <= 1'b0;
        end else begin
            stage1 <= port4_bit0;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

    assign wait_active = level;

endmodule

// [rtl/pointer_bank.sv]
// Two data pointers and the pointer select register
module pointer_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Special register write port
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic pointer_select_toggle,
    // Pointer control from the core
    input wire logic pointer_load,
    input wire logic [15:0] pointer_load_value,
    input wire logic pointer_inc,
    // State out
    output logic pointer_select,
    output logic [15:0] data_pointer_primary,
    output logic [15:0] data_pointer_secondary,
    output logic [15:0] selected_pointer
);

    logic next_select;
    logic [15:0] next_primary;
    logic [15:0] next_secondary;
    logic [15:0] next_selected;

    // Select bit, then load or increment of the selected pointer
    always_comb begin
        next_select = pointer_select;
        if (sfr_wr && sfr_addr == xmove_pkg::POINTER_SELECT_ADDR) begin
            next_select = sfr_wdata[xmove_pkg::POINTER_SELECT_BIT];
        end else if (pointer_select_toggle) begin
            next_select = ~pointer_select;
        end
        next_primary = data_pointer_primary;
        next_secondary = data_pointer_secondary;
        next_selected = pointer_select ? data_pointer_secondary : data_pointer_primary;
        if (pointer_load) begin
            next_selected = pointer_load_value;
        end else if (pointer_inc) begin
            next_selected = 16'(next_selected + 16'h0001);
        end
        if (pointer_select) begin
            next_secondary = next_selected;
        end else begin
            next_primary = next_selected;
        end
    end

    // Register the pointer state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pointer_select <= xmove_pkg::POINTER_SELECT_RESET;
            data_pointer_primary <= xmove_pkg::POINTER_RESET;
            data_pointer_secondary <= xmove_pkg::POINTER_RESET;
        end else begin
            pointer_select <= next_select;
            data_pointer_primary <= next_primary;
            data_pointer_secondary <= next_secondary;
        end
    end

    assign selected_pointer = pointer_select ? data_pointer_secondary : data_pointer_primary;

endmodule

// [verif/ext_data_access_chk.sv]
// Port-level assertions for the external-move access timing block
module ext_data_access_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register writes
    input wire logic clock_control_wr,
    input wire logic [7:0] clock_control_wdata,
    input wire logic memory_map_wr,
    input wire logic timed_access_open,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic pointer_select_toggle,
    // Access and state
    input wire logic xmove_req,
    input wire xmove_pkg::xmove_request_type xmove_cmd,
    input wire logic xmove_ready,
    input wire logic xmove_done,
    input wire xmove_pkg::xmem_bus_type mem_bus,
    input wire logic [7:0] clock_control_reg,
    input wire logic [7:0] memory_map_reg,
    input wire logic [7:0] pointer_select_reg,
    input wire logic [1:0] clock_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****
    // Access tracking
    // ****
    logic take, strobe, busy, wen;
    logic [2:0] n;
    logic [5:0] mc;
    logic [6:0] sc;
    logic [15:0] ri_addr;
    assign take = xmove_req && xmove_ready;
    assign strobe = !mem_bus.rd_n || !mem_bus.wr_n;
    // Settings latched at the take; the block snapshots stretch at the end of fetch and reads wait enable live
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            wen <= 1'b0;
            n <= 3'h0;
            mc <= 6'h00;
            sc <= 7'h00;
            ri_addr <= 16'h0000;
        end else if (take) begin
            busy <= 1'b1;
            wen <= memory_map_reg[7];
            n <= clock_control_reg[2:0];
            mc <= 6'h00;
            sc <= 7'h00;
            ri_addr <= {xmove_cmd.port2_latch, xmove_cmd.indirect_register};
        end else if (busy) begin
            busy <= !xmove_done;
            mc <= mc + {5'h00, clock_state == xmove_pkg::STATE_C4};
            sc <= sc + {6'h00, strobe};
        end
    end
    // ****
    // Properties
    // ****
    sequence s_quiet4;
        (mem_bus.rd_n && mem_bus.wr_n) [*4];
    endsequence
    property p_fetch;
        take |=> s_quiet4;
    endproperty
    a_fetch: assert property (p_fetch) else $error("strobe during opcode fetch");
    property p_phase;
        1'b1 |=> clock_state == $past(clock_state) + 2'h1;
    endproperty
    a_phase: assert property (p_phase) else $error("clock state out of order");
    property p_stretch;
        clock_control_wr |=> clock_control_reg == ($past(clock_control_wdata) & 8'h07);
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch field not written");
    property p_lock;
        memory_map_wr && !timed_access_open |=> $stable(memory_map_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("unprotected wait enable write");
    property p_bits;
        (memory_map_reg & 8'h7f) == 8'h00 && (pointer_select_reg & 8'hfe) == 8'h00;
    endproperty
    a_bits: assert property (p_bits) else $error("unused register bits set");
    property p_toggle;
        pointer_select_toggle && !(sfr_wr && sfr_addr == xmove_pkg::POINTER_SELECT_ADDR)
            |=> pointer_select_reg != $past(pointer_select_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("pointer select did not toggle");
    property p_addr;
        take && !xmove_cmd.use_pointer |=> mem_bus.address == ri_addr;
    endproperty
    a_addr: assert property (p_addr) else $error("indirect address wrong");
    property p_len;
        xmove_done && !wen |-> mc == {3'h0, n} + 6'h02 && clock_state == xmove_pkg::STATE_C1;
    endproperty
    a_len: assert property (p_len) else $error("move length wrong");
    property p_len_wait;
        xmove_done && wen |-> mc >= {3'h0, n} + 6'h02;
    endproperty
    a_len_wait: assert property (p_len_wait) else $error("wait move below minimum");
    property p_strobe;
        xmove_done |-> sc == (n == 3'h0 ? 7'h02 : {2'h0, n, 2'h0}) + {mc - {3'h0, n} - 6'h02, 2'h0};
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe width wrong");
endmodule

// [verif/xmem_model.sv]
// Behavioural external data memory that can hold the wait pin low
module xmem_model (
    // Clock
    input wire logic clk,
    // Bus from the block
    input wire xmove_pkg::xmem_bus_type mem_bus,
    output logic [7:0] mem_rdata,
    // Wait length chosen by the bench, in clocks
    input wire logic [7:0] hold_len,
    output logic port4_bit0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h00, cnt = 8'h00;
    logic [15:0] addr_q = 16'h0000;
    // Inverse when not read, so stale data never matches
    assign mem_rdata = !mem_bus.rd_n ? mem[mem_bus.address[7:0]] : ~last;
    // Pulled up when released; wait must end for the access to finish
    assign port4_bit0 = cnt == 8'h00;
    // A new address stalls at once, even the shortest access
    always @(posedge clk) begin
        addr_q <= mem_bus.address;
        if (!mem_bus.rd_n) last <= mem_rdata;
        if (!mem_bus.wr_n) mem[mem_bus.address[7:0]] <= mem_bus.write_data;
        if (mem_bus.address != addr_q) cnt <= hold_len;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
endmodule

// [verif/tb_ext_data_access.sv]
// Self-checking bench for the external-move access timing block
module tb_ext_data_access;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, clock_control_wr, memory_map_wr, timed_access_open, sfr_wr, pointer_select_toggle;
    logic pointer_load, pointer_inc, xmove_req, xmove_ready, xmove_done, core_hold, port4_bit0;
    logic [7:0] clock_control_wdata, memory_map_wdata, sfr_addr, sfr_wdata, read_data, mem_rdata, hold_len;
    logic [7:0] clock_control_reg, memory_map_reg, pointer_select_reg;
    logic [15:0] pointer_load_value, data_pointer_primary, data_pointer_secondary;
    logic [1:0] clock_state;
    xmove_pkg::xmove_request_type xmove_cmd;
    xmove_pkg::xmem_bus_type mem_bus;
    int err_total = 0, samples_checked = 0, mc, sc, hc;
    // Block and the memory on its far side
    ext_data_access i_dut (.*);
    xmem_model i_mem (.*);
    // Clock
    always #25 clk = ~clk;
    // ****
    // Helpers
    // ****
    task automatic tick;
        @(posedge clk);
        #5;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Second tick keeps back-to-back pulses apart
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick;
        s = 1'b0;
        tick;
    endtask
    task automatic set_stretch(input logic [2:0] n);
        clock_control_wdata = {5'h1f, n};
        pulse(clock_control_wr);
        check("stretch", clock_control_reg, {5'h00, n});
    endtask
    task automatic set_wait(input logic on);
        memory_map_wdata = {on, 7'h7f};
        timed_access_open = 1'b1;
        pulse(memory_map_wr);
        timed_access_open = 1'b0;
        check("wait_enable", memory_map_reg, {on, 7'h00});
    endtask
    // One move; counts cycle ends, strobe and hold clocks until done
    task automatic move(input logic wr, ptr, input logic [7:0] hi, lo, wd);
        int i;
        xmove_cmd = '{wr, ptr, lo, hi, wd};
        xmove_req = 1'b1;
        for (i = 0; i < 8 && xmove_ready !== 1'b1; i++) tick;
        tick;
        xmove_req = 1'b0;
        {mc, sc, hc} = '0;
        for (i = 0; i < 400 && xmove_done !== 1'b1; i++) begin
            mc += int'(clock_state == xmove_pkg::STATE_C4);
            hc += int'(core_hold);
            sc += int'(!mem_bus.rd_n || !mem_bus.wr_n);
            tick;
        end
        check("done", xmove_done, 1'b1);
    endtask
    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        check("ccr", clock_control_reg, 8'h01);
        check("map", memory_map_reg, 8'h00);
        check("dps", pointer_select_reg, 8'h00);
        check("hold", core_hold, 1'b0);
        move(1'b1, 1'b0, 8'h12, 8'h34, 8'h5a);
        check("default_len", mc, 3);
        check("default_strobe", sc, 4);
    endtask
    // Every stretch code, write then read back
    task automatic t_stretch;
        for (int n = 0; n < 8; n++) begin
            set_stretch(3'(n));
            move(1'b1, 1'b0, 8'h40, 8'(n), 8'(8'ha0 + n));
            check("write_len", mc, n + 2);
            check("strobe", sc, n == 0 ? 2 : 4 * n);
            check("hold_len", hc, 4 * n);
            check("addr", mem_bus.address, {8'h40, 8'(n)});
            check("wdata", mem_bus.write_data, 8'(8'ha0 + n));
            move(1'b0, 1'b0, 8'h40, 8'(n), 8'h00);
            check("read_len", mc, n + 2);
            check("rdata", read_data, 8'(8'ha0 + n));
        end
    endtask
    task automatic t_regs;
        memory_map_wdata = 8'hff;
        timed_access_open = 1'b0;
        pulse(memory_map_wr);
        check("unprotected", memory_map_reg, 8'h00);
        set_wait(1'b1);
        set_wait(1'b0);
    endtask
    // Wait pin: ignored when off, only lengthens when on
    task automatic t_wait;
        set_stretch(3'h0);
        hold_len = 8'h14;
        move(1'b0, 1'b0, 8'h50, 8'h01, 8'h00);
        check("no_wait", mc, 2);
        set_wait(1'b1);
        move(1'b1, 1'b0, 8'h50, 8'h02, 8'h11);
        check("wait_20", mc >= 5 && mc <= 8, 1'b1);
        hold_len = 8'h3c;
        move(1'b0, 1'b0, 8'h50, 8'h03, 8'h00);
        check("wait_60", mc >= 15 && mc <= 18, 1'b1);
        set_stretch(3'h3);
        hold_len = 8'h02;
        move(1'b0, 1'b0, 8'h50, 8'h04, 8'h00);
        check("wait_min", mc, 5);
        hold_len = 8'h00;
        set_wait(1'b0);
    endtask
    task automatic t_pointer;
        sfr_addr = 8'h86;
        sfr_wdata = 8'hff;
        pulse(sfr_wr);
        check("dps_set", pointer_select_reg, 8'h01);
        pulse(pointer_select_toggle);
        check("dps_toggle", pointer_select_reg, 8'h00);
        sfr_addr = 8'h87;
        pulse(sfr_wr);
        check("dps_other", pointer_select_reg, 8'h00);
        pointer_load_value = 16'h1234;
        pulse(pointer_load);
        pulse(pointer_select_toggle);
        pointer_load_value = 16'habcd;
        pulse(pointer_load);
        pulse(pointer_inc);
        check("primary", data_pointer_primary, 16'h1234);
        check("secondary", data_pointer_secondary, 16'habce);
        move(1'b0, 1'b1, 8'h00, 8'h00, 8'h00);
        check("addr_sec", mem_bus.address, 16'habce);
        pulse(pointer_select_toggle);
        move(1'b0, 1'b1, 8'h00, 8'h00, 8'h00);
        check("addr_pri", mem_bus.address, 16'h1234);
    endtask
    // Main sequence
    initial begin
        clk = 1'b0;
        {rstn, clock_control_wr, memory_map_wr, timed_access_open, sfr_wr, pointer_select_toggle} = '0;
        {pointer_load, pointer_inc, xmove_req, clock_control_wdata, memory_map_wdata} = '0;
        {sfr_addr, sfr_wdata, hold_len, pointer_load_value, xmove_cmd} = '0;
        repeat (20) @(posedge clk);
        #5 rstn = 1'b1;
        tick;
        t_reset;
        t_stretch;
        t_regs;
        t_wait;
        t_pointer;
        finish_test;
    end
    // Watchdog: scenarios need under a thousand cycles
    initial begin
        #(50 * 20000);
        err_total++;
        finish_test;
    end
endmodule
bind ext_data_access ext_data_access_chk i_chk (.*);
